// >>> hdl/host_port_pkg.sv
// constants and types shared by the 8-bit host bus adapter
// assumes one clock (sys_clk) and the strap pins held stable around reset release
package host_port_pkg;

   // ********************
   // strap decoding
   // ********************
   localparam logic [2:0] MODE_STROBE16 = 3'h4;

   typedef struct packed {
      logic [1:0] clkDiv;
      logic waitPol;
      logic byteOrder;
      logic pinFn;
      logic [2:0] busMode;
   } straps_t;

   localparam straps_t STRAPS_RESET = '{2'h0, 1'h0, 1'h0, 1'h0, 3'h0};

   // ********************
   // address spaces
   // ********************
   localparam int BUF_BYTES = 81920;
   localparam int BUF_WORDS = BUF_BYTES / 2;
   localparam int REG_WORDS = 16;
   localparam logic [15:0] BUF_LIMIT = 16'ha000;

   // ********************
   // refresh arbitration
   // ********************
   localparam logic [7:0] REFRESH_PERIOD = 8'h40;
   localparam logic [3:0] REFRESH_LEN = 4'h8;

   // ********************
   // software registers
   // ********************
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam int CTRL_REFRESH_BIT = 0;
   localparam int CTRL_GPIO_LSB = 8;
   localparam int GPIO_WIDTH = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam int STATUS_MODE_BIT = 8;
   localparam int STATUS_BUSY_BIT = 9;
   localparam int STATUS_PEND_BIT = 10;
   localparam int STATUS_GPIO_LSB = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ACC_IDLE = 3'h1,
      ACC_ARB = 3'h2,
      ACC_HOLD = 3'h4
   } access_state_t;

endpackage : host_port_pkg

// >>> hdl/bus_clock_divider.sv
// bus/memory tick generator: one pulse every 1 to 4 input clocks
// assumes divSel is stable once the straps are latched
`timescale 1ns/1ps
`default_nettype none
module bus_clock_divider (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [1:0] divSel,
   output logic tick
);
   logic [1:0] count;
   logic [1:0] next_count;

   always_comb begin
      next_count = (count >= divSel) ? 2'h0 : count + 2'h1;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         count <= 2'h0;
      end else begin
         count <= next_count;
      end
   end

   // bus and memory share this one tick, both derived from sys_clk
   assign tick = (count == divSel);

   property p_tick_quarter;
      @(posedge sys_clk) disable iff (!rstn)
      (tick && divSel == 2'h3 && $stable(divSel)) |=> !tick [*3] ##1 tick;
   endproperty
   a_tick_quarter: assert property (p_tick_quarter)
      else $error("4:1 bus tick spacing wrong");

   property p_tick_full;
      @(posedge sys_clk) disable iff (!rstn)
      (divSel == 2'h0) |-> tick;
   endproperty
   a_tick_full: assert property (p_tick_full)
      else $error("1:1 bus tick missing");
endmodule : bus_clock_divider
`default_nettype wire

// >>> hdl/refresh_arbiter.sv
// periodic display refresh slot that contends with host accesses
// assumes enable comes from a software register
`timescale 1ns/1ps
`default_nettype none
module refresh_arbiter (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic enable,
   output logic busy
);
   logic [7:0] gap;
   logic [7:0] next_gap;
   logic [3:0] left;
   logic [3:0] next_left;

   localparam logic [7:0] REFRESH_PERIOD_M1 = host_port_pkg::REFRESH_PERIOD - 8'h1;

   always_comb begin
      next_gap = gap;
      next_left = left;
      if (left != 4'h0) begin
         next_left = left - 4'h1;
      end else if (gap >= REFRESH_PERIOD_M1) begin
         next_gap = 8'h0;
         next_left = enable ? host_port_pkg::REFRESH_LEN : 4'h0;
      end else begin
         next_gap = gap + 8'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         gap <= 8'h0;
         left <= 4'h0;
      end else begin
         gap <= next_gap;
         left <= next_left;
      end
   end

   assign busy = (left != 4'h0);

   property p_busy_len;
      @(posedge sys_clk) disable iff (!rstn)
      $rose(busy) |-> busy [*8] ##1 !busy;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("refresh slot length wrong");
endmodule : refresh_arbiter
`default_nettype wire

// >>> hdl/eight_bit_host_bus_adapter.sv
// host bus port in 16-bit strobe mode, wired for an 8-bit processor
// assumes host pins synchronous to sys_clk; the board ties glue as listed
// What this block does
// - straps at reset release; 100 selects strobe mode
// - host pins behave only after reset release
// - pin strap high inputs, low panel outputs
// - byte-order strap: high big, low little endian
// - wait polarity strap: high active-high wait
// - one input clock feeds bus and memory
// - select low registers, high display buffer
// - 17 address bits reach 80K byte buffer
// - wait held through refresh contention until done
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module eight_bit_host_bus_adapter (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [2:0] bus_mode_straps,
   input wire logic pin_function_strap,
   input wire logic byte_order_strap,
   input wire logic wait_polarity_strap,
   input wire logic [1:0] clock_divide_straps,
   input wire logic [16:0] host_address_inputs,
   input wire logic [15:0] hostDataIn,
   output logic [15:0] hostDataOut,
   output logic hostDataOe,
   input wire logic chipSelect_n,
   input wire logic memRegSelect,
   input wire logic high_byte_enable_n,
   input wire logic write_strobe_n,
   input wire logic readStrobe_n,
   input wire logic bus_start_n,
   input wire logic readWriteDir,
   output logic waitPin,
   input wire logic [3:0] gpioIn,
   output logic [3:0] gpioOut,
   output logic [3:0] gpioOe,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp
);
   // ********************
   // strap capture
   // ********************
   host_port_pkg::straps_t straps;
   host_port_pkg::straps_t next_straps;
   logic latched;
   logic modeActive;

   always_comb begin
      next_straps = straps;
      if (!latched) begin
         next_straps = '{clock_divide_straps, wait_polarity_strap, byte_order_strap,
                         pin_function_strap, bus_mode_straps};
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         straps <= host_port_pkg::STRAPS_RESET;
         latched <= 1'b0;
      end else begin
         straps <= next_straps;
         latched <= 1'b1;
      end
   end

   // nothing on the host side responds until the straps are in
   assign modeActive = latched && (straps.busMode == host_port_pkg::MODE_STROBE16);

   // ********************
   // clocking and refresh
   // ********************
   logic tick;
   logic refreshBusy;
   logic [31:0] ctrl;

   bus_clock_divider u_div (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .divSel(straps.clkDiv),
      .tick(tick)
   );

   refresh_arbiter u_refresh (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .enable(ctrl[host_port_pkg::CTRL_REFRESH_BIT]),
      .busy(refreshBusy)
   );

   // ********************
   // host access
   // ********************
   host_port_pkg::access_state_t state;
   host_port_pkg::access_state_t next_state;
   logic access;
   logic readCycle;
   logic go;
   logic waitActive;
   logic [15:0] wordIdx;
   logic [15:0] storedWord;
   logic [15:0] laneData;
   logic [1:0] laneEn;
   logic [15:0] readData;
   logic [15:0] next_readData;
   logic [15:0] displayBuf [host_port_pkg::BUF_WORDS];
   logic [15:0] regFile [host_port_pkg::REG_WORDS];

   // bus start and direction pins carry nothing in this mode
   assign access = !chipSelect_n && (!readStrobe_n || !write_strobe_n);
   assign readCycle = !readStrobe_n;
   assign wordIdx = host_address_inputs[16:1];
   assign go = (state == host_port_pkg::ACC_ARB) && access && tick && !refreshBusy;

   always_comb begin
      storedWord = 16'h0;
      if (memRegSelect) begin
         if (wordIdx < host_port_pkg::BUF_LIMIT) begin
            storedWord = displayBuf[wordIdx];
         end
      end else if (host_address_inputs[16:5] == 12'h0) begin
         storedWord = regFile[host_address_inputs[4:1]];
      end
   end

   // big endian swaps the lanes against the stored word
   always_comb begin
      laneEn = {!high_byte_enable_n, !host_address_inputs[0]};
      laneData = hostDataIn;
      if (straps.byteOrder) begin
         laneEn = {!host_address_inputs[0], !high_byte_enable_n};
         laneData = {hostDataIn[7:0], hostDataIn[15:8]};
      end
   end

   always_comb begin
      next_state = state;
      next_readData = readData;
      if (go && readCycle) begin
         next_readData = straps.byteOrder ? {storedWord[7:0], storedWord[15:8]}
                                          : storedWord;
      end
      unique case (state)
         host_port_pkg::ACC_IDLE: begin
            if (modeActive && access) begin
               next_state = host_port_pkg::ACC_ARB;
            end
         end
         host_port_pkg::ACC_ARB: begin
            if (!access) begin
               next_state = host_port_pkg::ACC_IDLE;
            end else if (go) begin
               next_state = host_port_pkg::ACC_HOLD;
            end
         end
         host_port_pkg::ACC_HOLD: begin
            if (!access) begin
               next_state = host_port_pkg::ACC_IDLE;
            end
         end
         default: begin
            next_state = host_port_pkg::ACC_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state <= host_port_pkg::ACC_IDLE;
         readData <= 16'h0;
      end else begin
         state <= next_state;
         readData <= next_readData;
      end
   end

   // storage has no reset; contents are undefined at power on
   always_ff @(posedge sys_clk) begin
      if (go && !readCycle) begin
         if (memRegSelect && wordIdx < host_port_pkg::BUF_LIMIT) begin
            if (laneEn[1]) displayBuf[wordIdx][15:8] <= laneData[15:8];
            if (laneEn[0]) displayBuf[wordIdx][7:0] <= laneData[7:0];
         end else if (!memRegSelect && host_address_inputs[16:5] == 12'h0) begin
            if (laneEn[1]) regFile[host_address_inputs[4:1]][15:8] <= laneData[15:8];
            if (laneEn[0]) regFile[host_address_inputs[4:1]][7:0] <= laneData[7:0];
         end
      end
   end

   // wait rises with the strobe, drops when data is ready or taken
   assign waitActive = modeActive && access && (state != host_port_pkg::ACC_HOLD);
   assign waitPin = straps.waitPol ? waitActive : !waitActive;
   assign hostDataOut = readData;
   assign hostDataOe = modeActive && access && readCycle && (state == host_port_pkg::ACC_HOLD);

   // ********************
   // general purpose pins
   // ********************
   assign gpioOut = ctrl[host_port_pkg::CTRL_GPIO_LSB +: host_port_pkg::GPIO_WIDTH];
   assign gpioOe = (latched && !straps.pinFn) ? 4'hf : 4'h0;

   // ********************
   // register slave
   // ********************
   logic awHave;
   logic wHave;
   logic [7:0] awaddrHeld;
   logic [31:0] wdataHeld;
   logic [3:0] wstrbHeld;
   logic [31:0] next_ctrl;
   logic next_awHave;
   logic next_wHave;
   logic [7:0] next_awaddrHeld;
   logic [31:0] next_wdataHeld;
   logic [3:0] next_wstrbHeld;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic [31:0] status;

   assign awready = !awHave && !bvalid;
   assign wready = !wHave && !bvalid;
   assign arready = !rvalid;
   assign status = {12'h0, gpioIn, 5'h0, state == host_port_pkg::ACC_ARB, refreshBusy,
                    modeActive, straps};

   always_comb begin
      next_ctrl = ctrl;
      next_awHave = awHave;
      next_wHave = wHave;
      next_awaddrHeld = awaddrHeld;
      next_wdataHeld = wdataHeld;
      next_wstrbHeld = wstrbHeld;
      next_bvalid = bvalid && !bready;
      next_bresp = bresp;
      next_rvalid = rvalid && !rready;
      next_rdata = rdata;
      next_rresp = rresp;
      if (awvalid && awready) begin
         next_awHave = 1'b1;
         next_awaddrHeld = awaddr;
      end
      if (wvalid && wready) begin
         next_wHave = 1'b1;
         next_wdataHeld = wdata;
         next_wstrbHeld = wstrb;
      end
      if (awHave && wHave && !bvalid) begin
         next_awHave = 1'b0;
         next_wHave = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = host_port_pkg::RESP_SLVERR;
         if (awaddrHeld == host_port_pkg::CTRL_OFFSET) begin
            next_bresp = host_port_pkg::RESP_OKAY;
            for (int i = 0; i < 4; i++) begin
               if (wstrbHeld[i]) next_ctrl[8*i +: 8] = wdataHeld[8*i +: 8];
            end
         end else if (awaddrHeld == host_port_pkg::STATUS_OFFSET) begin
            next_bresp = host_port_pkg::RESP_OKAY;
         end
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rdata = 32'h0;
         next_rresp = host_port_pkg::RESP_OKAY;
         if (araddr == host_port_pkg::CTRL_OFFSET) begin
            next_rdata = ctrl;
         end else if (araddr == host_port_pkg::STATUS_OFFSET) begin
            next_rdata = status;
         end else begin
            next_rresp = host_port_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= host_port_pkg::CTRL_RESET;
         awHave <= 1'b0;
         wHave <= 1'b0;
         awaddrHeld <= 8'h0;
         wdataHeld <= 32'h0;
         wstrbHeld <= 4'h0;
         bvalid <= 1'b0;
         bresp <= 2'h0;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= 2'h0;
      end else begin
         ctrl <= next_ctrl;
         awHave <= next_awHave;
         wHave <= next_wHave;
         awaddrHeld <= next_awaddrHeld;
         wdataHeld <= next_wdataHeld;
         wstrbHeld <= next_wstrbHeld;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   // ********************
   // checks
   // ********************
   property p_mode_select;
      @(posedge sys_clk) disable iff (!rstn)
      (latched && !$past(latched)) |-> modeActive == ($past(bus_mode_straps) == 3'h4);
   endproperty
   a_mode_select: assert property (p_mode_select)
      else $error("bus mode not taken from straps");

   property p_quiet_before_latch;
      @(posedge sys_clk) disable iff (!rstn)
      !latched |-> (!waitActive && !hostDataOe && gpioOe == 4'h0);
   endproperty
   a_quiet_before_latch: assert property (p_quiet_before_latch)
      else $error("host pins active before straps latched");

   property p_gpio_dir;
      @(posedge sys_clk) disable iff (!rstn)
      latched |-> (gpioOe == (straps.pinFn ? 4'h0 : 4'hf));
   endproperty
   a_gpio_dir: assert property (p_gpio_dir)
      else $error("pin direction does not follow strap");

   property p_byte_order;
      @(posedge sys_clk) disable iff (!rstn)
      (latched && !$past(latched)) |-> straps.byteOrder == $past(byte_order_strap) ##1
      $stable(straps.byteOrder);
   endproperty
   a_byte_order: assert property (p_byte_order)
      else $error("byte order not latched at release");

   property p_wait_polarity;
      @(posedge sys_clk) disable iff (!rstn)
      (modeActive && access && state == host_port_pkg::ACC_IDLE) |-> waitPin == straps.waitPol;
   endproperty
   a_wait_polarity: assert property (p_wait_polarity)
      else $error("wait pin polarity wrong");

   property p_wait_on_start;
      @(posedge sys_clk) disable iff (!rstn)
      (modeActive && access && state == host_port_pkg::ACC_IDLE) |-> waitActive
      ##1 (!access || state == host_port_pkg::ACC_ARB);
   endproperty
   a_wait_on_start: assert property (p_wait_on_start)
      else $error("wait not raised at access start");

   property p_wait_bound;
      @(posedge sys_clk) disable iff (!rstn)
      (state == host_port_pkg::ACC_ARB && access) |-> ##[0:40]
      (!access || state == host_port_pkg::ACC_HOLD);
   endproperty
   a_wait_bound: assert property (p_wait_bound)
      else $error("wait held too long");

   property p_no_go_in_refresh;
      @(posedge sys_clk) disable iff (!rstn)
      refreshBusy |-> !go ##1 (state != host_port_pkg::ACC_HOLD || $past(state) ==
      host_port_pkg::ACC_HOLD);
   endproperty
   a_no_go_in_refresh: assert property (p_no_go_in_refresh)
      else $error("access completed during refresh");

   property p_buffer_limit;
      @(posedge sys_clk) disable iff (!rstn)
      (go && readCycle && memRegSelect && wordIdx >= host_port_pkg::BUF_LIMIT) |=>
      readData == 16'h0;
   endproperty
   a_buffer_limit: assert property (p_buffer_limit)
      else $error("read past buffer end not zero");

endmodule : eight_bit_host_bus_adapter
`default_nettype wire

// >>> tb/host_cpu_model.sv
// 8-bit processor plus glue logic as seen from the adapter's host pins
// assumes access is called just after a rising edge of sys_clk
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
   input wire logic sys_clk,
   input wire logic waitPin,
   input wire logic waitHigh,
   input wire logic [15:0] hostDataOut,
   input wire logic hostDataOe,
   output logic [16:0] addr,
   output logic [15:0] dataOut,
   output logic cs_n,
   output logic memSel,
   output logic hiByteEn_n,
   output logic we_n,
   output logic rd_n,
   output logic tieHigh
);
   // ***************
   // bus cycle
   // ***************
   logic [7:0] cpuByte;
   assign dataOut = {cpuByte, cpuByte};
   assign hiByteEn_n = ~addr[0];
   assign tieHigh = 1'h1;
   initial begin
      addr = 17'h0;
      cpuByte = 8'h0;
      cs_n = 1'h1;
      memSel = 1'h0;
      we_n = 1'h1;
      rd_n = 1'h1;
   end
   // cycle stays frozen while wait is asserted (level set by waitHigh); capped so a hang cannot stall the run
   task automatic access(input logic wr, input logic sp, input logic [16:0] a,
         input logic [7:0] d, output logic [7:0] q, output int waits);
      logic busy;
      waits = 0;
      busy = 1'h1;
      q = 8'h0;
      addr <= a;
      memSel <= sp;
      cs_n <= 1'h0;
      cpuByte <= wr ? d : ~cpuByte;
      we_n <= ~wr;
      rd_n <= wr;
      while (busy && waits < 40) begin
         @(negedge sys_clk);
         busy = waitPin !== !waitHigh;
         if (hostDataOe === 1'h1)
            q = a[0] ? hostDataOut[15:8] : hostDataOut[7:0];
         @(posedge sys_clk);
         if (busy)
            waits++;
      end
      cs_n <= 1'h1;
      we_n <= 1'h1;
      rd_n <= 1'h1;
      // released lines float: show a changed value, not the last one
      cpuByte <= ~cpuByte;
      @(posedge sys_clk);
   endtask : access
endmodule : host_cpu_model
`default_nettype wire

// >>> tb/eight_bit_host_bus_adapter_tb_top.sv
// self-checking bench for the 8-bit host bus adapter
// assumes the package and the processor model are compiled first
`timescale 1ns/1ps
`default_nettype none
module eight_bit_host_bus_adapter_tb_top;
   // ***************
   // harness
   // ***************
   typedef struct packed {
      logic sp;
      logic [16:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } row_t;
   localparam row_t ROWS [6] = '{
      '{1'h1, 17'h00002, 8'h5a, 8'h5a},
      '{1'h1, 17'h00003, 8'ha5, 8'ha5},
      '{1'h0, 17'h00002, 8'h3c, 8'h3c},
      '{1'h1, 17'h10004, 8'hc3, 8'hc3},
      '{1'h1, 17'h00004, 8'h96, 8'h96},
      '{1'h1, 17'h14001, 8'h77, 8'h00}};
   logic sys_clk, rstn, dOe, cs_n, memSel, hiByteEn_n, we_n, rd_n, tieHigh, waitPin;
   logic [16:0] addr;
   logic [15:0] dIn, dOut;
   logic [3:0] gpioOut, gpioOe;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr, q;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rs;
   host_port_pkg::straps_t st, s;
   int failCount, nChecks, w, mx;
   eight_bit_host_bus_adapter dut (.sys_clk(sys_clk), .rstn(rstn),
      .bus_mode_straps(st.busMode), .pin_function_strap(st.pinFn),
      .byte_order_strap(st.byteOrder), .wait_polarity_strap(st.waitPol),
      .clock_divide_straps(st.clkDiv), .host_address_inputs(addr), .hostDataIn(dIn),
      .hostDataOut(dOut), .hostDataOe(dOe), .chipSelect_n(cs_n), .memRegSelect(memSel),
      .high_byte_enable_n(hiByteEn_n), .write_strobe_n(we_n), .readStrobe_n(rd_n),
      .bus_start_n(tieHigh), .readWriteDir(tieHigh), .waitPin(waitPin), .gpioIn(4'h6),
      .gpioOut(gpioOut), .gpioOe(gpioOe), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp));
   host_cpu_model cpu (.sys_clk(sys_clk), .waitPin(waitPin), .waitHigh(st.waitPol),
      .hostDataOut(dOut), .hostDataOe(dOe), .addr(addr), .dataOut(dIn), .cs_n(cs_n),
      .memSel(memSel), .hiByteEn_n(hiByteEn_n), .we_n(we_n), .rd_n(rd_n),
      .tieHigh(tieHigh));
   initial begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      nChecks++;
      if (got !== exp) begin
         failCount++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check
   task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      logic aRdy, wRdy, rsp, go;
      go = 1'h1;
      if (wr) begin
         awaddr <= a;
         wdata <= wd;
         awvalid <= 1'h1;
         wvalid <= 1'h1;
         bready <= 1'h1;
      end else begin
         araddr <= a;
         arvalid <= 1'h1;
         rready <= 1'h1;
      end
      for (int i = 0; i < 40 && go; i++) begin
         @(negedge sys_clk);
         aRdy = wr ? awready : arready;
         wRdy = wr && wready;
         rsp = wr ? bvalid : rvalid;
         rd = rdata;
         rs = wr ? bresp : rresp;
         @(posedge sys_clk);
         if (aRdy) begin
            awvalid <= 1'h0;
            arvalid <= 1'h0;
         end
         if (wRdy)
            wvalid <= 1'h0;
         if (rsp) begin
            bready <= 1'h0;
            rready <= 1'h0;
            go = 1'h0;
         end
      end
      check(32'(go), 32'h0, "axi answer");
      @(posedge sys_clk);
   endtask : axi
   task automatic doReset(input host_port_pkg::straps_t x);
      rstn <= 1'h0;
      st <= x;
      repeat (8) @(posedge sys_clk);
      check(32'({waitPin, dOe}), 32'h2, "pins idle in reset");
      rstn <= 1'h1;
      repeat (3) @(posedge sys_clk);
   endtask : doReset
   task automatic finalReport();
      $display("checks %0d mismatches %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finalReport
   // ***************
   // scenarios
   // ***************
   initial begin
      rstn = 1'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wdata} = 48'h0;
      failCount = 0;
      nChecks = 0;
      st = '{2'h0, 1'h0, 1'h0, 1'h1, 3'h5};
      doReset(st);
      cpu.access(1'h0, 1'h1, 17'h2, 8'h0, q, w);
      check(32'(w), 32'h0, "foreign mode stalls");
      axi(1'h0, host_port_pkg::STATUS_OFFSET, 32'h0);
      check(32'(rd[8]), 32'h0, "port active");
      for (int k = 3; k >= 0; k--) begin
         // little endian, active-low wait for the 8-bit host
         s = '{k[1:0], 1'h0, 1'h0, k[0], host_port_pkg::MODE_STROBE16};
         doReset(s);
         axi(1'h0, host_port_pkg::STATUS_OFFSET, 32'h0);
         check(32'(rd[8:0]), 32'({1'h1, s}), "latched straps");
         check(32'(gpioOe), 32'({4{~k[0]}}), "pin function");
         cpu.access(1'h1, 1'h1, 17'h11, {6'h0c, k[1:0]}, q, w);
         cpu.access(1'h0, 1'h1, 17'h11, 8'h0, q, w);
         check(32'(q), 32'({6'h0c, k[1:0]}), "divided clock access");
      end
      axi(1'h1, host_port_pkg::CTRL_OFFSET, 32'h900);
      check(32'({rs, gpioOut}), 32'h9, "ctrl write");
      axi(1'h0, host_port_pkg::CTRL_OFFSET, 32'h0);
      check(rd, 32'h900, "ctrl read");
      axi(1'h0, 8'h08, 32'h0);
      check({rd[29:0], rs}, 32'(host_port_pkg::RESP_SLVERR), "unmapped read");
      axi(1'h1, 8'h0c, 32'h1);
      check(32'(rs), 32'(host_port_pkg::RESP_SLVERR), "unmapped write");
      for (int i = 0; i < 12; i++) begin
         cpu.access(i < 6, ROWS[i % 6].sp, ROWS[i % 6].a, ROWS[i % 6].d, q, w);
         check(32'(w), 32'h2, "quiet access stall");
         if (i >= 6)
            check(32'(q), 32'(ROWS[i % 6].e), "readback");
      end
      // refresh back on: some accesses must collide and stretch
      axi(1'h1, host_port_pkg::CTRL_OFFSET, 32'h1);
      mx = 0;
      repeat (40) begin
         cpu.access(1'h0, 1'h1, 17'h2, 8'h0, q, w);
         check(32'(q), 32'h5a, "read under refresh");
         if (w > mx)
            mx = w;
      end
      check(32'(mx > 2 && mx <= 16), 32'h1, "refresh stretches wait");
      s = '{2'h0, 1'h1, 1'h1, 1'h1, host_port_pkg::MODE_STROBE16};
      doReset(s);
      axi(1'h0, host_port_pkg::STATUS_OFFSET, 32'h0);
      check(32'({rd[19:16], rd[7:0]}), 32'({4'h6, s}), "byte order and wait straps");
      check(32'(waitPin), 32'h0, "active-high wait idles low");
      // big endian: an odd byte lands in the low half of the stored word
      cpu.access(1'h1, 1'h1, 17'h21, 8'h6b, q, w);
      cpu.access(1'h0, 1'h1, 17'h21, 8'h0, q, w);
      check(32'(q), 32'h6b, "big endian readback");
      // storage survives reset, so the swap shows from the little-endian side
      s = '{2'h0, 1'h0, 1'h0, 1'h1, host_port_pkg::MODE_STROBE16};
      doReset(s);
      cpu.access(1'h0, 1'h1, 17'h20, 8'h0, q, w);
      check(32'(q), 32'h6b, "lanes swapped in big endian");
      finalReport();
   end
   // whole run is a few hundred cycles
   initial begin
      #60000;
      failCount++;
      $display("BAD %0t watchdog expired", $time);
      finalReport();
   end
endmodule : eight_bit_host_bus_adapter_tb_top
`default_nettype wire
